// [rie_consts.vh]
`ifndef RIE_CONSTS_VH
`define RIE_CONSTS_VH

// Instruction word, program counter, literal and interrupt control register widths
`define RIE_INSTR_W 14
`define RIE_PC_W 13
`define RIE_LIT_W 8
`define RIE_ICTL_W 8

// Opcode encodings
`define RIE_OP_NOP 14'h0000
`define RIE_OP_RETURN 14'h0008
`define RIE_OP_RETI 14'h0009
`define RIE_OP_RETK 14'h3400
`define RIE_OP_RETK_MASK 14'h3C00

// Global interrupt enable position in the interrupt control register
`define RIE_IEN_BIT 7

// Instruction cycle timing
`define RIE_CLK_NS 50
`define RIE_INSTR_CYC_NS 200
`define RIE_CYC_CLKS ((`RIE_INSTR_CYC_NS + `RIE_CLK_NS - 1) / `RIE_CLK_NS)

// Instruction lengths in instruction cycles
`define RIE_RET_CYCLES 2
`define RIE_NOP_CYCLES 1

// Decoded operation classes
`define RIE_CLS_OTHER 3'h0
`define RIE_CLS_NOP 3'h1
`define RIE_CLS_RETURN 3'h2
`define RIE_CLS_RETI 3'h3
`define RIE_CLS_RETK 3'h4

`endif

// [rie_return_exec.v]
`timescale 1ns/10ps
`include "rie_consts.vh"

module rie_return_exec
#(
  parameter CYC_CLKS = `RIE_CYC_CLKS
)
(
  input wire clk,
  input wire arst_n,
  input wire instrValid,
  input wire [`RIE_INSTR_W-1:0] instrWord,
  input wire [`RIE_PC_W-1:0] pcCur,
  input wire [`RIE_PC_W-1:0] stackTop,
  output reg cycEnOut_r,
  output reg busy_r,
  output reg stackPop_r,
  output reg pcLoad_r,
  output reg [`RIE_PC_W-1:0] pcValue_r,
  output reg wLoad_r,
  output reg [`RIE_LIT_W-1:0] wValue_r,
  output reg ictlSet_r,
  output reg [`RIE_ICTL_W-1:0] ictlSetMask_r,
  output reg foreignOp_r,
  output reg instrDone_r,
  output reg [2:0] doneClass_r
);

  localparam ST_EXEC = 1'b0;
  localparam ST_FLUSH = 1'b1;
  localparam [1:0] RET_LAST = `RIE_RET_CYCLES - 1;

  // Sorts a fetched word into the operations this block owns
  function [2:0] opClass;
    input [`RIE_INSTR_W-1:0] word;
    begin
      if ((word & `RIE_OP_RETK_MASK) == `RIE_OP_RETK)
      begin
        opClass = `RIE_CLS_RETK;
      end
      else if (word == `RIE_OP_RETI)
      begin
        opClass = `RIE_CLS_RETI;
      end
      else if (word == `RIE_OP_RETURN)
      begin
        opClass = `RIE_CLS_RETURN;
      end
      else if (word == `RIE_OP_NOP)
      begin
        opClass = `RIE_CLS_NOP;
      end
      else
      begin
        opClass = `RIE_CLS_OTHER;
      end
    end
  endfunction

  reg [7:0] divCnt_r;
  reg [7:0] divCnt_nxt;
  reg cycEn;
  reg state_r;
  reg state_nxt;
  reg [1:0] cycLeft_r;
  reg [1:0] cycLeft_nxt;
  reg [2:0] curClass_r;
  reg [2:0] curClass_nxt;
  reg [2:0] fetchClass;
  reg [`RIE_ICTL_W-1:0] ienMask;

  // Instruction cycle enable; the whole core steps on this pulse only
  always @*
  begin
    cycEn = (divCnt_r == CYC_CLKS - 1);
    if (cycEn)
    begin
      divCnt_nxt = 8'h00;
    end
    else
    begin
      divCnt_nxt = divCnt_r + 8'h01;
    end
  end

  always @*
  begin
    ienMask = {`RIE_ICTL_W{1'b0}};
    ienMask[`RIE_IEN_BIT] = 1'b1;
    fetchClass = opClass(instrWord);
  end

  always @*
  begin
    state_nxt = state_r;
    cycLeft_nxt = cycLeft_r;
    curClass_nxt = curClass_r;
    if (cycEn)
    begin
      case (state_r)
        ST_EXEC:
        begin
          if (instrValid && (fetchClass == `RIE_CLS_RETURN ||
              fetchClass == `RIE_CLS_RETI ||
              fetchClass == `RIE_CLS_RETK))
          begin
            // Second cycle discards the prefetched word
            state_nxt = ST_FLUSH;
            cycLeft_nxt = RET_LAST;
            curClass_nxt = fetchClass;
          end
        end
        ST_FLUSH:
        begin
          if (cycLeft_r <= 2'h1)
          begin
            state_nxt = ST_EXEC;
            cycLeft_nxt = 2'h0;
          end
          else
          begin
            cycLeft_nxt = cycLeft_r - 2'h1;
          end
        end
        default:
        begin
          state_nxt = ST_EXEC;
          cycLeft_nxt = 2'h0;
        end
      endcase
    end
  end

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      divCnt_r <= 8'h00;
      state_r <= ST_EXEC;
      cycLeft_r <= 2'h0;
      curClass_r <= `RIE_CLS_OTHER;
    end
    else
    begin
      divCnt_r <= divCnt_nxt;
      state_r <= state_nxt;
      cycLeft_r <= cycLeft_nxt;
      curClass_r <= curClass_nxt;
    end
  end

  // Strobe outputs are one-clock pulses aligned with the cycle enable; busy_r stays high through the whole flush cycle
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cycEnOut_r <= 1'b0;
      busy_r <= 1'b0;
      stackPop_r <= 1'b0;
      pcLoad_r <= 1'b0;
      pcValue_r <= {`RIE_PC_W{1'b0}};
      wLoad_r <= 1'b0;
      wValue_r <= {`RIE_LIT_W{1'b0}};
      ictlSet_r <= 1'b0;
      ictlSetMask_r <= {`RIE_ICTL_W{1'b0}};
      foreignOp_r <= 1'b0;
      instrDone_r <= 1'b0;
      doneClass_r <= `RIE_CLS_OTHER;
    end
    else
    begin
      cycEnOut_r <= cycEn;
      stackPop_r <= 1'b0;
      pcLoad_r <= 1'b0;
      wLoad_r <= 1'b0;
      ictlSet_r <= 1'b0;
      ictlSetMask_r <= {`RIE_ICTL_W{1'b0}};
      foreignOp_r <= 1'b0;
      instrDone_r <= 1'b0;
      busy_r <= (state_nxt == ST_FLUSH);
      // No status flag write exists here at all
      if (cycEn && state_r == ST_EXEC && instrValid)
      begin
        case (fetchClass)
          `RIE_CLS_NOP:
          begin
            pcLoad_r <= 1'b1;
            pcValue_r <= pcCur + {{(`RIE_PC_W-1){1'b0}}, 1'b1};
            instrDone_r <= 1'b1;
            doneClass_r <= `RIE_CLS_NOP;
          end
          `RIE_CLS_RETURN:
          begin
            stackPop_r <= 1'b1;
            pcLoad_r <= 1'b1;
            pcValue_r <= stackTop;
          end
          `RIE_CLS_RETI:
          begin
            stackPop_r <= 1'b1;
            pcLoad_r <= 1'b1;
            pcValue_r <= stackTop;
            ictlSet_r <= 1'b1;
            ictlSetMask_r <= ienMask;
          end
          `RIE_CLS_RETK:
          begin
            stackPop_r <= 1'b1;
            pcLoad_r <= 1'b1;
            pcValue_r <= stackTop;
            wLoad_r <= 1'b1;
            wValue_r <= instrWord[`RIE_LIT_W-1:0];
          end
          default:
          begin
            // Left to the rest of the decoder
            foreignOp_r <= 1'b1;
          end
        endcase
      end
      else if (cycEn && state_r == ST_FLUSH && state_nxt == ST_EXEC)
      begin
        instrDone_r <= 1'b1;
        doneClass_r <= curClass_r;
      end
    end
  end

endmodule

// [rie_ret_sva.sv]
`timescale 1ns/10ps
module rie_ret_sva
#(parameter CYC_CLKS = 4)
(
  input wire clk,
  input wire arst_n,
  input wire instrValid,
  input wire [13:0] instrWord,
  input wire [12:0] pcCur,
  input wire [12:0] stackTop,
  input wire cycEnOut_r,
  input wire busy_r,
  input wire stackPop_r,
  input wire pcLoad_r,
  input wire [12:0] pcValue_r,
  input wire wLoad_r,
  input wire [7:0] wValue_r,
  input wire ictlSet_r,
  input wire [7:0] ictlSetMask_r,
  input wire foreignOp_r,
  input wire instrDone_r,
  input wire [2:0] doneClass_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_pop; stackPop_r |-> pcValue_r == $past(stackTop); endproperty
  a_pop: assert property (p_pop) else $error("pop pc");
  property p_two; stackPop_r |-> busy_r ##CYC_CLKS instrDone_r; endproperty
  a_two: assert property (p_two) else $error("two cycles");
  property p_end; $fell(busy_r) |-> instrDone_r && cycEnOut_r; endproperty
  a_end: assert property (p_end) else $error("flush end");
  property p_ien; ictlSet_r |-> ictlSetMask_r == 8'h80; endproperty
  a_ien: assert property (p_ien) else $error("enable mask");
  property p_iop; ictlSet_r |-> $past(instrWord) == 14'h0009; endproperty
  a_iop: assert property (p_iop) else $error("enable op");
  property p_lit; wLoad_r |-> wValue_r == $past(instrWord[7:0]); endproperty
  a_lit: assert property (p_lit) else $error("literal");
  property p_wpop; wLoad_r |-> stackPop_r && !ictlSet_r; endproperty
  a_wpop: assert property (p_wpop) else $error("lit pop");
  property p_inc;
    pcLoad_r && !busy_r |-> pcValue_r == $past(pcCur) + 13'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("nop pc");
  c_ien: cover property (ictlSet_r);
  c_lit: cover property (wLoad_r);
  c_nop: cover property (pcLoad_r && !busy_r);
  c_ret: cover property (stackPop_r && !wLoad_r && !ictlSet_r);
endmodule
bind rie_return_exec rie_ret_sva #(.CYC_CLKS(CYC_CLKS)) sva (.*);

// [testbench.sv]
`timescale 1ns/10ps
module testbench;
  reg clk = 1'b0;
  reg arst_n = 1'b0;
  reg instrValid = 1'b0;
  reg [13:0] instrWord = 14'h0000;
  reg [12:0] pcCur = 13'h0000;
  reg [12:0] stackTop = 13'h0000;
  wire cycEnOut_r, busy_r, stackPop_r, pcLoad_r, wLoad_r, ictlSet_r;
  wire foreignOp_r, instrDone_r;
  wire [12:0] pcValue_r;
  wire [7:0] wValue_r, ictlSetMask_r;
  wire [2:0] doneClass_r;
  integer fails = 0;
  integer num_checks = 0;
  integer n, i;
  reg [31:0] sd = 32'h74F5F730;
  always #25 clk = ~clk;
  rie_return_exec dut (.*);
  function [31:0] xs(input [31:0] s);
    begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      xs = s ^ (s << 5);
    end
  endfunction
  function [2:0] cls(input [13:0] v);
    cls = v == 14'h0000 ? 3'h1 : v == 14'h0008 ? 3'h2 :
      v == 14'h0009 ? 3'h3 : v[13:10] == 4'hD ? 3'h4 : 3'h0;
  endfunction
  task end_of_test;
    begin
      if (fails == 0 && num_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [31:0] a, input [31:0] b);
    begin
      num_checks = num_checks + 1;
      if (a !== b)
      begin
        fails = fails + 1;
        $display("Error %0t %h %h", $time, a, b);
      end
    end
  endtask
  task wt(input s);
    begin
      n = 0;
      @(negedge clk);
      while ((s ? instrDone_r : cycEnOut_r) !== 1'b1 && n < 9)
      begin
        @(negedge clk);
        n = n + 1;
      end
      if (n == 9)
      begin
        fails = fails + 1;
        end_of_test;
      end
    end
  endtask
  task run(input [13:0] v, input [12:0] pc, input [12:0] stk);
    reg [2:0] c;
    reg r;
    reg [12:0] np;
    begin
      c = cls(v);
      r = c > 3'h1;
      np = pc + 13'h1;
      instrWord = v;
      pcCur = pc;
      stackTop = stk;
      wt(1'b0);
      chk({stackPop_r, pcLoad_r, wLoad_r, ictlSet_r, foreignOp_r,
        instrDone_r, busy_r}, {r, c != 3'h0, c == 3'h4, c == 3'h3,
        c == 3'h0, c == 3'h1, r});
      chk(ictlSetMask_r, c == 3'h3 ? 8'h80 : 8'h00);
      if (c != 3'h0) chk(pcValue_r, c == 3'h1 ? np : stk);
      if (c == 3'h1) chk(doneClass_r, 3'h1);
      if (c == 3'h4) chk(wValue_r, v[7:0]);
      if (r)
      begin
        // Flushed slot must ignore a fetched word
        instrWord = 14'h0009;
        wt(1'b1);
        chk({n[7:0], busy_r, stackPop_r, doneClass_r}, {8'h03, 2'b00, c});
      end
    end
  endtask
  initial
  begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    wt(1'b0);
    chk({stackPop_r, pcLoad_r, foreignOp_r}, 3'h0);
    instrValid = 1'b1;
    run(14'h34FF, 13'h0000, 13'h1FFF);
    run(14'h3400, 13'h0123, 13'h0000);
    run(14'h0000, 13'h1FFF, 13'h0000);
    run(14'h0009, 13'h0010, 13'h1234);
    run(14'h0008, 13'h0020, 13'h0ABC);
    // Reset in the middle of a flush must drop the pending completion
    instrWord = 14'h0009;
    wt(1'b0);
    chk(busy_r, 1'b1);
    arst_n = 1'b0;
    @(negedge clk);
    chk({busy_r, stackPop_r, pcLoad_r, ictlSet_r, instrDone_r, cycEnOut_r,
      doneClass_r, pcValue_r}, 32'h0);
    arst_n = 1'b1;
    run(14'h0000, 13'h0042, 13'h0000);
    for (i = 0; i < 300; i = i + 1)
    begin
      sd = xs(sd);
      run(sd[1] ? (sd[0] ? sd[29:16] : {4'hD, sd[25:16]}) :
        (sd[0] ? {13'h0004, sd[2]} : 14'h0000), sd[28:16], sd[12:0]);
    end
    end_of_test;
  end
endmodule
